//--- core/ddrmr_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// Shared constants of the mode register block
// ---------------------------------------------------------------
package ddrmr_pkg;
  // Clock period and derived timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TRP_PS = 15000;          // Precharge time
  localparam int TRP_CYC = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [5:0] TRP_CYC_W = 6'(TRP_CYC);
  localparam logic [5:0] CWL_CYC = 6'h05; // Write latency base, fixed

  // Bank codes that select a mode register
  localparam logic [2:0] BA_BURST_LAT = 3'h0;
  localparam logic [2:0] BA_DLL_TERM = 3'h1;

  // Reset values of the two mode registers
  localparam logic [15:0] BURST_LAT_RST = 16'h0000;
  localparam logic [15:0] DLL_TERM_RST = 16'h0000;

  // Burst/latency register field positions
  localparam int BL_LO = 0;               // Burst length field, 2 bits
  localparam int CL_EXT = 2;              // Latency extension bit
  localparam int BT_BIT = 3;              // Interleaved burst order
  localparam int CL_LO = 4;               // Latency field, 3 bits
  localparam int TM_BIT = 7;              // Manufacturer test mode
  localparam int DLLRST_BIT = 8;          // Self-clearing DLL reset
  localparam int WR_LO = 9;               // Write recovery, 3 bits
  localparam int PPD_BIT = 12;            // Power-down fast exit

  // DLL/termination register field positions
  localparam int DLLDIS_BIT = 0;          // 1 disables the DLL
  localparam int AL_LO = 3;               // Additive latency, 2 bits
  localparam int QOFF_BIT = 12;           // Output disable

  // Burst length encodings
  localparam logic [1:0] BL_EIGHT = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP = 2'h2;

  // Latency arithmetic
  localparam logic [4:0] CL_BASE = 5'h04;
  localparam logic [4:0] CL_EXT_ADD = 5'h08;
  localparam logic [2:0] LAST_BEAT = 3'h7;
  localparam logic [2:0] CHOP_LAST = 3'h3;
  localparam logic [2:0] COMMIT_EARLY = 3'h5; // Two beats before the end

  // Write recovery lookup, indexed by the 3-bit code
  localparam logic [4:0] WR_TABLE [8] = '{
    5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E
  };

  // Burst sequencer states, one-hot
  typedef enum logic [2:0] {
    DDRMR_IDLE = 3'h1,
    DDRMR_WAIT = 3'h2,
    DDRMR_BURST = 3'h4
  } ddrmr_state_e;
endpackage : ddrmr_pkg
`default_nettype wire

//--- core/ddrmr_col_gen.sv
`default_nettype none
// ---------------------------------------------------------------
// Column order within one burst
// ---------------------------------------------------------------
module ddrmr_col_gen (
  input wire logic [2:0] start_i,
  input wire logic [2:0] beat_i,
  input wire logic interleave_i,
  input wire logic write_i,
  input wire logic chop_i,
  output logic [2:0] col_o
);
  logic [1:0] low_sum; // Wrapping sum inside a group of four

  // Order is pure combinational, the caller registers it
  always_comb begin
    low_sum = 2'(start_i[1:0] + beat_i[1:0]);
    if (write_i) begin
      // Writes ignore low start bits, chop keeps only A2
      col_o = chop_i ? {start_i[2], beat_i[1:0]} : beat_i;
    end else if (interleave_i) begin
      col_o = start_i ^ beat_i; // Interleaved order
    end else begin
      col_o = {start_i[2] ^ beat_i[2], low_sum}; // Sequential
    end
  end
endmodule : ddrmr_col_gen
`default_nettype wire

//--- core/ddrmr_top.sv
`default_nettype none
// Notes on behaviour
// - Recovery plus precharge gives auto-precharge delay.
// - Data starts whole read latency after command.
// - A3 picks sequential or interleaved order.
// - A1-A0 pick chop, eight, or per-command.
// - Read order wraps or exclusive-ORs start.
// - Chopped read drives four beats then floats.
// - Writes use natural order, chop uses A2.
// - Fixed chop commits write two cycles earlier.
// - DLL reset bit clears itself after use.
// - A12 chooses frozen or running DLL power-down.
// - DLL stops in self refresh, resumes after.
// - Writes need DLL only with write termination.
// - A4-A3 add zero, latency minus one or two.
module ddrmr_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cke_i,          // Clock enable from controller
  input wire logic cs_n_i,         // Command pins, on this clock
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  input wire logic rtt_wr_en_i,    // Write termination is enabled
  output logic rd_oe_o,            // Data and strobe drivers on
  output logic [2:0] rd_col_o,     // Column of the beat driven
  output logic wr_take_o,          // A write beat is captured
  output logic [2:0] wr_col_o,     // Column of the captured beat
  output logic wr_commit_o,        // Internal write start pulse
  output logic dll_reset_o,        // DLL reset pulse
  output logic dll_active_o,       // DLL running
  output logic fast_pd_exit_o,     // Short power-down exit delay
  output logic test_mode_o,        // Test mode selected
  output logic write_needs_dll_o,  // Writes rely on the DLL
  output logic [4:0] cas_lat_o,
  output logic [4:0] add_lat_o,
  output logic [5:0] rd_lat_o,
  output logic [4:0] wr_rec_o,
  output logic [5:0] ap_wr_delay_o
);
  import ddrmr_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] burst_latency_config_reg;
    logic [15:0] dll_termination_config_reg;
    logic cke_prev;                // Clock enable one cycle ago
    logic self_ref;                // In self refresh
    logic pwr_down;                // In power-down
    ddrmr_state_e rd_state;
    logic [5:0] rd_cnt;            // Latency countdown
    logic [2:0] rd_beat;
    logic [2:0] rd_start;
    logic rd_chop;
    ddrmr_state_e wr_state;
    logic [5:0] wr_cnt;
    logic [2:0] wr_beat;
    logic [2:0] wr_start;
    logic wr_chop;
    logic wr_fixed_chop;           // Chop set by mode, not command
    logic rd_oe;
    logic [2:0] rd_col;
    logic wr_take;
    logic [2:0] wr_col;
    logic wr_commit;
    logic dll_reset;
    logic dll_active;
    logic fast_pd;
    logic test_mode;
    logic wr_dll;
    logic [4:0] cas_lat;
    logic [4:0] add_lat;
    logic [5:0] rd_lat;
    logic [4:0] wr_rec;
    logic [5:0] ap_delay;
  } ddrmr_state_s;

  ddrmr_state_s s_q;
  ddrmr_state_s s_d;

  // ---------------------------------------------------------------
  // Command decode and burst column order
  // ---------------------------------------------------------------
  logic sel;       // Chip selected
  logic cmd_mrs;   // Mode register set
  logic cmd_ref;   // Refresh, self refresh when CKE falls
  logic cmd_rd;
  logic cmd_wr;
  logic rd_chop_cmd;
  logic [2:0] rd_col_next;
  logic [2:0] wr_col_next;
  logic [2:0] rd_beat_next;
  logic [2:0] wr_beat_next;

  assign sel = ~cs_n_i & s_q.cke_prev;
  assign cmd_mrs = sel & ~ras_n_i & ~cas_n_i & ~we_n_i;
  assign cmd_ref = sel & ~ras_n_i & ~cas_n_i & we_n_i;
  assign cmd_rd = sel & ras_n_i & ~cas_n_i & we_n_i & cke_i;
  assign cmd_wr = sel & ras_n_i & ~cas_n_i & ~we_n_i & cke_i;

  // Chop either fixed by mode or taken from A12 per command
  always_comb begin
    case (s_q.burst_latency_config_reg[BL_LO +: 2])
      BL_CHOP: rd_chop_cmd = 1'b1;
      BL_OTF: rd_chop_cmd = ~addr_i[12];
      default: rd_chop_cmd = 1'b0;
    endcase
  end

  // Beat that the next clock will present
  assign rd_beat_next = (s_q.rd_state == DDRMR_WAIT) ? 3'h0
                      : 3'(s_q.rd_beat + 3'h1);
  assign wr_beat_next = (s_q.wr_state == DDRMR_WAIT) ? 3'h0
                      : 3'(s_q.wr_beat + 3'h1);

  // Read column order
  ddrmr_col_gen u_rd_col (
    .start_i(s_q.rd_start),
    .beat_i(rd_beat_next),
    .interleave_i(s_q.burst_latency_config_reg[BT_BIT]),
    .write_i(1'b0),
    .chop_i(s_q.rd_chop),
    .col_o(rd_col_next)
  );

  // Write column order
  ddrmr_col_gen u_wr_col (
    .start_i(s_q.wr_start),
    .beat_i(wr_beat_next),
    .interleave_i(s_q.burst_latency_config_reg[BT_BIT]),
    .write_i(1'b1),
    .chop_i(s_q.wr_chop),
    .col_o(wr_col_next)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [4:0] cl;
    logic [4:0] al;
    logic [2:0] wr_end;
    cl = 5'h00;
    al = 5'h00;
    wr_end = LAST_BEAT;
    s_d = s_q;
    s_d.cke_prev = cke_i;
    s_d.dll_reset = 1'b0;
    s_d.wr_commit = 1'b0;
    s_d.wr_take = 1'b0;

    // Mode registers change only on their own command, except the self-clearing DLL reset bit
    if (cmd_mrs && ba_i == BA_BURST_LAT) begin
      s_d.burst_latency_config_reg = addr_i;
    end else if (cmd_mrs && ba_i == BA_DLL_TERM) begin
      s_d.dll_termination_config_reg = addr_i;
    end else if (s_q.burst_latency_config_reg[DLLRST_BIT]) begin
      // Reset issued last cycle, the bit drops back to zero
      s_d.burst_latency_config_reg[DLLRST_BIT] = 1'b0;
    end
    // Pulse once per reset request
    s_d.dll_reset = cmd_mrs && ba_i == BA_BURST_LAT
                    && addr_i[DLLRST_BIT];

    // Self refresh entry and exit, power-down otherwise
    if (cmd_ref && !cke_i) begin
      s_d.self_ref = 1'b1;
    end else if (cke_i) begin
      s_d.self_ref = 1'b0;
      s_d.pwr_down = 1'b0;
    end else if (s_q.cke_prev && !s_q.self_ref) begin
      s_d.pwr_down = 1'b1;
    end

    // DLL stops in self refresh and in slow-exit power-down
    s_d.dll_active = ~s_q.dll_termination_config_reg[DLLDIS_BIT]
                     & ~s_q.self_ref
                     & ~(s_q.pwr_down
                         & ~s_q.burst_latency_config_reg[PPD_BIT]);
    s_d.fast_pd = s_q.burst_latency_config_reg[PPD_BIT];
    s_d.test_mode = s_q.burst_latency_config_reg[TM_BIT];
    // Only write termination ties writes to the DLL
    s_d.wr_dll = rtt_wr_en_i;

    // Latency decode; reserved additive code reads as zero
    cl = 5'(CL_BASE + {2'h0, s_q.burst_latency_config_reg[CL_LO +: 3]});
    if (s_q.burst_latency_config_reg[CL_EXT]) begin
      cl = 5'(cl + CL_EXT_ADD);
    end
    case (s_q.dll_termination_config_reg[AL_LO +: 2])
      2'h1: al = 5'(cl - 5'h01);
      2'h2: al = 5'(cl - 5'h02);
      default: al = 5'h00;
    endcase
    s_d.cas_lat = cl;
    s_d.add_lat = al;
    s_d.rd_lat = 6'({1'b0, al} + {1'b0, cl});
    s_d.wr_rec = WR_TABLE[s_q.burst_latency_config_reg[WR_LO +: 3]];
    s_d.ap_delay = 6'({1'b0, s_d.wr_rec} + TRP_CYC_W);

    // Read sequencer: one read in flight, later ones dropped
    case (s_q.rd_state)
      DDRMR_IDLE: begin
        s_d.rd_oe = 1'b0;
        if (cmd_rd) begin
          s_d.rd_state = DDRMR_WAIT;
          s_d.rd_cnt = s_q.rd_lat;
          s_d.rd_start = addr_i[2:0];
          s_d.rd_chop = rd_chop_cmd;
        end
      end
      DDRMR_WAIT: begin
        s_d.rd_cnt = 6'(s_q.rd_cnt - 6'h01);
        if (s_q.rd_cnt <= 6'h01) begin
          s_d.rd_state = DDRMR_BURST;
          s_d.rd_beat = rd_beat_next;
          s_d.rd_col = rd_col_next;
          // Drivers stay off while outputs are disabled
          s_d.rd_oe = ~s_q.dll_termination_config_reg[QOFF_BIT];
        end
      end
      DDRMR_BURST: begin
        s_d.rd_beat = rd_beat_next;
        s_d.rd_col = rd_col_next;
        if (s_q.rd_beat == CHOP_LAST && s_q.rd_chop) begin
          s_d.rd_oe = 1'b0; // Float for the last four slots
        end
        if (s_q.rd_beat == LAST_BEAT) begin
          s_d.rd_state = DDRMR_IDLE;
          s_d.rd_oe = 1'b0;
        end
      end
      default: begin
        s_d.rd_state = DDRMR_IDLE;
        s_d.rd_oe = 1'b0;
      end
    endcase
    // Write sequencer, same latency shape with the write base
    wr_end = s_q.wr_fixed_chop ? COMMIT_EARLY : LAST_BEAT;
    case (s_q.wr_state)
      DDRMR_IDLE: begin
        if (cmd_wr) begin
          s_d.wr_state = DDRMR_WAIT;
          s_d.wr_cnt = 6'({1'b0, s_q.add_lat} + CWL_CYC);
          s_d.wr_start = addr_i[2:0];
          s_d.wr_chop = rd_chop_cmd;
          s_d.wr_fixed_chop =
            s_q.burst_latency_config_reg[BL_LO +: 2] == BL_CHOP;
        end
      end
      DDRMR_WAIT: begin
        s_d.wr_cnt = 6'(s_q.wr_cnt - 6'h01);
        if (s_q.wr_cnt <= 6'h01) begin
          s_d.wr_state = DDRMR_BURST;
          s_d.wr_beat = wr_beat_next;
          s_d.wr_col = wr_col_next;
          s_d.wr_take = 1'b1;
        end
      end
      DDRMR_BURST: begin
        s_d.wr_beat = wr_beat_next;
        s_d.wr_col = wr_col_next;
        // Beats after a chop are don't-care and not captured
        s_d.wr_take = ~(s_q.wr_chop && s_q.wr_beat >= CHOP_LAST)
                      && s_q.wr_beat != LAST_BEAT;
        // Fixed chop starts the internal write two beats early
        s_d.wr_commit = (s_q.wr_beat == wr_end);
        if (s_q.wr_beat == LAST_BEAT) begin
          s_d.wr_state = DDRMR_IDLE;
        end
      end
      default: s_d.wr_state = DDRMR_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Settings start from zero; controller must program both first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.burst_latency_config_reg <= BURST_LAT_RST;
      s_q.dll_termination_config_reg <= DLL_TERM_RST;
      s_q.rd_state <= DDRMR_IDLE;
      s_q.wr_state <= DDRMR_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, each straight from a flip-flop
  assign rd_oe_o = s_q.rd_oe;
  assign rd_col_o = s_q.rd_col;
  assign wr_take_o = s_q.wr_take;
  assign wr_col_o = s_q.wr_col;
  assign wr_commit_o = s_q.wr_commit;
  assign dll_reset_o = s_q.dll_reset;
  assign dll_active_o = s_q.dll_active;
  assign fast_pd_exit_o = s_q.fast_pd;
  assign test_mode_o = s_q.test_mode;
  assign write_needs_dll_o = s_q.wr_dll;
  assign cas_lat_o = s_q.cas_lat;
  assign add_lat_o = s_q.add_lat;
  assign rd_lat_o = s_q.rd_lat;
  assign wr_rec_o = s_q.wr_rec;
  assign ap_wr_delay_o = s_q.ap_delay;
endmodule : ddrmr_top
`default_nettype wire

//--- dv/ddrmr_props.sv
`default_nettype none
// -------------------------------------------
// Timing and decode checks at the top ports
// -------------------------------------------
module ddrmr_props
  import ddrmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  input wire logic rtt_wr_en_i,
  input wire logic rd_oe_o,
  input wire logic wr_take_o,
  input wire logic wr_commit_o,
  input wire logic dll_reset_o,
  input wire logic fast_pd_exit_o,
  input wire logic write_needs_dll_o,
  input wire logic [4:0] cas_lat_o,
  input wire logic [4:0] add_lat_o,
  input wire logic [5:0] rd_lat_o,
  input wire logic [4:0] wr_rec_o,
  input wire logic [5:0] ap_wr_delay_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Load of the burst/latency register
  wire logic mrs0 = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i
    && ba_i == BA_BURST_LAT;

  dll_pulse_a: assert property (
    mrs0 && addr_i[8] && $past(cke_i) |=> dll_reset_o ##1 !dll_reset_o)
    else $error("dll reset pulse wrong");
  pd_exit_a: assert property (
    mrs0 && $past(cke_i) |-> ##2 fast_pd_exit_o == $past(addr_i[12], 2))
    else $error("power-down exit choice wrong");
  rd_lat_a: assert property (
    rd_lat_o == 6'(cas_lat_o) + 6'(add_lat_o))
    else $error("read latency sum wrong");
  add_lat_a: assert property (
    add_lat_o == 5'h00 || add_lat_o == cas_lat_o - 5'h01
    || add_lat_o == cas_lat_o - 5'h02)
    else $error("additive latency out of set");
  ap_delay_a: assert property (
    wr_rec_o != 5'h00 |-> ap_wr_delay_o == 6'(wr_rec_o) + TRP_CYC_W)
    else $error("auto-precharge delay wrong");
  oe_len_a: assert property (
    $rose(rd_oe_o) |-> rd_oe_o [*4] ##5 !rd_oe_o)
    else $error("read drive length wrong");
  commit_a: assert property (
    $fell(wr_take_o) |-> ##[0:4] wr_commit_o)
    else $error("write commit missing");
  needs_dll_a: assert property (
    $past(reset_n_i) |-> write_needs_dll_o == $past(rtt_wr_en_i))
    else $error("write dll need wrong");
  hold_a: assert property (
    !$past(mrs0, 2) && $past(reset_n_i, 2) |-> $stable(cas_lat_o))
    else $error("latency changed without load");
endmodule : ddrmr_props

bind ddrmr_top ddrmr_props ddrmr_props_i (.clk_i, .reset_n_i, .cke_i,
  .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i, .addr_i, .rtt_wr_en_i,
  .rd_oe_o, .wr_take_o, .wr_commit_o, .dll_reset_o, .fast_pd_exit_o,
  .write_needs_dll_o, .cas_lat_o, .add_lat_o, .rd_lat_o, .wr_rec_o,
  .ap_wr_delay_o);
`default_nettype wire

//--- dv/ddrmr_ctrl_model.sv
`default_nettype none
// -------------------------------------------
// Controller model on the command pins
// -------------------------------------------
module ddrmr_ctrl_model #(
  parameter int LOCK_CYC = 24 // DLL lock wait, plain default
) (
  input wire logic clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o,
  output logic rtt_wr_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins at time zero
  initial begin
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    ba_o = 3'h0;
    addr_o = 16'h0000;
    rtt_wr_en_o = 1'b0;
  end
  // One command, then deselect; released pins flip, not hold
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
    input logic [15:0] a);
    @(posedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    ba_o <= b;
    addr_o <= a;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    ba_o <= ~b;
    addr_o <= ~a;
  endtask : cmd
  // Register load with reserved and unsafe bits cleaned
  task automatic mrs(input logic [2:0] b, input logic [15:0] v);
    logic [15:0] a;
    a = v & 16'h1FFF; // Reserved top bits low
    if (b == 3'h0) begin
      a[7] = 1'b0; // Normal mode only
    end
    if (b == 3'h1) begin
      a = a & 16'h18FF; // Reserved low, mild termination
      if (a[0]) begin
        a = a & 16'hFFBB; // Termination off while DLL off
      end
    end
    cmd(4'h0, b, a); // Bank code picks register, DLL on first
    if (b == 3'h1) begin
      rtt_wr_en_o <= !a[0]; // Write termination only with DLL
    end
    if (b == 3'h0 && a[8]) begin
      repeat (LOCK_CYC) @(posedge clk_i); // Lock wait, cke high
    end
  endtask : mrs
  // Read or write; A12 low picks chop per command
  task automatic rw(input logic wr, input logic [2:0] s, input logic a12);
    cmd({3'b010, !wr}, 3'h0, {3'h0, a12, 9'h000, s});
  endtask : rw
  // Self refresh entry with clock enable low, exit raises it
  task automatic sr(input logic enter);
    @(posedge clk_i);
    cke_o <= !enter;
    if (enter) begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h1;
      @(posedge clk_i);
      cs_n_o <= 1'b1;
    end
  endtask : sr
  // Power-down entry or exit: clock enable only, no command
  task automatic pd(input logic enter);
    @(posedge clk_i);
    cke_o <= !enter;
  endtask : pd
endmodule : ddrmr_ctrl_model
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
// -------------------------------------------
// Bench for the mode register block
// -------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddrmr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, rtt_wr_en_i;
  logic [2:0] ba_i, rd_col_o, wr_col_o;
  logic [15:0] addr_i;
  logic rd_oe_o, wr_take_o, wr_commit_o, dll_reset_o, dll_active_o;
  logic fast_pd_exit_o, test_mode_o, write_needs_dll_o;
  logic [4:0] cas_lat_o, add_lat_o, wr_rec_o;
  logic [5:0] rd_lat_o, ap_wr_delay_o;
  logic [15:0] r0 = 16'h0000; // Expected register contents
  logic [15:0] r1 = 16'h0000;
  logic [15:0] cv [4] = '{16'h0E74, 16'h1080, 16'h0000, 16'h0B52};
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int cl_e = 4;
  int al_e = 0;
  integer seed = 32'hac96;

  always #2.5 clk_i = ~clk_i;
  ddrmr_ctrl_model ddrmr_ctrl_model_i (.clk_i, .cke_o(cke_i),
    .cs_n_o(cs_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i),
    .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i),
    .rtt_wr_en_o(rtt_wr_en_i));
  ddrmr_top ddrmr_top_i (.clk_i, .reset_n_i, .cke_i, .cs_n_i, .ras_n_i,
    .cas_n_i, .we_n_i, .ba_i, .addr_i, .rtt_wr_en_i, .rd_oe_o, .rd_col_o,
    .wr_take_o, .wr_col_o, .wr_commit_o, .dll_reset_o, .dll_active_o,
    .fast_pd_exit_o, .test_mode_o, .write_needs_dll_o, .cas_lat_o,
    .add_lat_o, .rd_lat_o, .wr_rec_o, .ap_wr_delay_o);

  // -------------------------------------------
  // Expectations and checking
  // -------------------------------------------
  function automatic logic [4:0] exp_wr(input logic [2:0] c);
    return c == 3'h0 ? 5'h10 : c < 3'h5 ? 5'(c) + 5'h04 : 5'(c) * 5'h02;
  endfunction : exp_wr
  function automatic logic [2:0] exp_col(input logic [2:0] s, k,
    input logic il, wr, chop);
    if (wr) return chop ? {s[2], k[1:0]} : k;
    return il ? s ^ k : {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction : exp_col
  task automatic chk(input logic [5:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s %0d/%0d", $time, what, got, exp);
    end
  endtask : chk
  // Decoded outputs two edges after a load
  task automatic dec_chk();
    repeat (2) @(posedge clk_i);
    #1;
    cl_e = 4 + int'(r0[6:4]) + (r0[2] ? 8 : 0);
    al_e = r1[4:3] == 2'h1 ? cl_e - 1 : r1[4:3] == 2'h2 ? cl_e - 2 : 0;
    chk(cas_lat_o, 6'(cl_e), "cl");
    chk(add_lat_o, 6'(al_e), "al");
    chk(rd_lat_o, 6'(cl_e + al_e), "rl");
    chk(wr_rec_o, exp_wr(r0[11:9]), "wr");
    chk(ap_wr_delay_o, 6'(exp_wr(r0[11:9])) + TRP_CYC_W, "apd");
    chk(fast_pd_exit_o, r0[12], "pd");
    chk(test_mode_o, 1'b0, "tm");
  endtask : dec_chk
  task automatic ld(input logic [2:0] b, input logic [15:0] v);
    ddrmr_ctrl_model_i.mrs(b, v);
    if (b == 3'h0) r0 = v;
    if (b == 3'h1) r1 = v;
    dec_chk();
  endtask : ld
  // One burst, with the slot after it watched too
  task automatic xfer(input logic wr, input logic a12);
    logic [2:0] s;
    logic ch;
    int n;
    s = 3'($random(seed));
    ch = r0[1:0] == BL_CHOP || (r0[1:0] == BL_OTF && !a12);
    n = ch ? 4 : 8;
    ddrmr_ctrl_model_i.rw(wr, s, a12);
    repeat (wr ? int'(CWL_CYC) + al_e : cl_e + al_e) @(posedge clk_i);
    for (int j = 0; j < 9; j++) begin
      #1;
      if (wr) begin
        chk(wr_take_o, j < n, "take");
        chk(wr_commit_o, j == (r0[1:0] == BL_CHOP ? 6 : 8), "cm");
        if (j < n) chk(wr_col_o, exp_col(s, 3'(j), 0, 1, ch), "wc");
      end else begin
        chk(rd_oe_o, !r1[12] && j < n, "oe");
        if (!r1[12] && j < n)
          chk(rd_col_o, exp_col(s, 3'(j), r0[3], 0, ch), "rc");
      end
      @(posedge clk_i);
    end
  endtask : xfer
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial begin : main
    logic [15:0] v;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    dec_chk();
    ld(3'h1, 16'h0008);
    ld(3'h0, 16'h0100);
    chk(dll_active_o, 1'b1, "dll");
    foreach (cv[i]) ld(3'h0, cv[i]);
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      v[1:0] = v[1:0] % 2'h3;
      ld(3'h0, v);
    end
    for (int c = 0; c < 4; c++) ld(3'h1, 16'(c) << 3);
    ld(3'h2, 16'h0050);
    $display("test decode done");
    ld(3'h1, 16'h0008);
    for (int m = 0; m < 6; m++) begin
      ld(3'h0, 16'h0020 | 16'(m % 3) | 16'(m / 3) << 3);
      for (int k = 0; k < 4; k++) begin
        xfer(1'b0, k[0]);
        xfer(1'b1, k[0]);
      end
    end
    ld(3'h1, 16'h1008);
    xfer(1'b0, 1'b0);
    $display("test bursts done");
    ld(3'h1, 16'h0049);
    chk(dll_active_o, 1'b0, "dll");
    ld(3'h1, 16'h0008);
    ld(3'h0, r0 | 16'h0100);
    ddrmr_ctrl_model_i.sr(1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    chk(dll_active_o, 1'b0, "dll");
    ddrmr_ctrl_model_i.sr(1'b0);
    repeat (3) @(posedge clk_i);
    #1;
    chk(dll_active_o, 1'b1, "dll");
    // Slow exit freezes the DLL in power-down, fast exit keeps it
    ddrmr_ctrl_model_i.pd(1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    chk(dll_active_o, 1'b0, "pd dll");
    ddrmr_ctrl_model_i.pd(1'b0);
    ld(3'h0, r0 | 16'h1000);
    ddrmr_ctrl_model_i.pd(1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    chk(dll_active_o, 1'b1, "pd dll");
    ddrmr_ctrl_model_i.pd(1'b0);
    $display("test dll done");
    test_done();
  end
endmodule : tb
`default_nettype wire
